// ==== logic/ryvs_sampler.sv ====
// RGB/YUV video input sampler with capture window, clamp and gain-correction pulses
//
// Contract
// - Sample RGB when RGB select set, otherwise sample YUV.
// - Interlaced RGB accepted only when interlace enable set; else progressive.
// - One ADC samples rising clock edges; two ADCs sample both edges.
// - Capture only pixels inside programmable offset and length window.
// - Offset counters start at second edge of vertical and horizontal sync.
// - Sync inputs interpreted with separately programmable polarities.
// - Vertical offset counted in lines, horizontal offset in pixels.
// - Single ADC takes port A; dual ADC alternates ports A and B.
// - Sequence flag picks first port after active horizontal sync edge.
// - Clamp pulse timed in half dot clock units.
// - Clamp on/off counts from second hsync edge; polarity programmable.
// - Gain pulse copies hsync with separate edge delays and polarity.
// - Gain pulse delays counted in half dot clock units.
// - Two-bit format: 656 embedded, 4:1:1, 4:2:2, 4:4:4.
// - Embedded mode ignores external syncs, uses embedded codes only.
// - Other YUV formats use syncs; reference input marks video and chroma start.
// - YUV uses same window values, relative to whole frame.
// - Field policy: all, alternate, odd only, even only.
// - YUV clocked by alternate clock when clock select set.
// - YUV sampled only while qualifier asserted at programmed polarity.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module ryvs_sampler (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic [ryvs_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [ryvs_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ryvs_pkg::DATA_W-1:0]   reg_rdata,
  input  wire ryvs_pkg::ryvs_pins_type       pins_in,
  output ryvs_pkg::ryvs_pixel_type           pixel_out,
  output logic                               clamp_out,
  output logic                               gain_correction_out
);

  localparam int CW = ryvs_pkg::CNT_W;

  // Window test on a counter
  function automatic logic in_window(input logic [CW-1:0] cnt,
                                     input logic [CW-1:0] off,
                                     input logic [CW-1:0] len);
    logic [CW:0] rel;
    rel = {1'b0, cnt} - {1'b0, off};
    in_window = (cnt >= off) && (rel < {1'b0, len});
  endfunction : in_window

  // Saturating increment
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + 12'h001;
  endfunction : sat_inc

  // Registers
  logic [15:0]   ctrl_q;
  logic [CW-1:0] v_off_q;
  logic [CW-1:0] h_off_q;
  logic [CW-1:0] v_len_q;
  logic [CW-1:0] h_len_q;
  logic [CW-1:0] clamp_on_q;
  logic [CW-1:0] clamp_off_q;
  logic [CW-1:0] gainc_on_q;
  logic [CW-1:0] gainc_off_q;
  logic [15:0]   rdata_q;

  // Synchronisers and edge history
  ryvs_pkg::ryvs_pins_type sync1_q;
  ryvs_pkg::ryvs_pins_type sync2_q;
  ryvs_pkg::ryvs_pins_type prev_q;

  // Counters and state
  logic [CW-1:0] hcnt_q;
  logic [CW-1:0] vcnt_q;
  logic [CW-1:0] hu_q;
  logic [CW-1:0] g_lead_q;
  logic [CW-1:0] g_trail_q;
  logic          g_lead_arm_q;
  logic          g_trail_arm_q;
  logic          g_act_q;
  logic          half_ph_q;
  logic          sel_b_q;
  logic          field_q;
  logic          capture_q;
  logic          last_fid_q;
  logic          first_frame_q;
  logic          first_line_q;
  logic          code_v_q;
  logic          code_act_q;
  ryvs_pkg::ryvs_code_state_type cs_q;
  ryvs_pkg::ryvs_pixel_type      pix_q;
  logic          clamp_q;

  // Control fields
  logic       rgb_on;
  logic       dual;
  logic [1:0] yuv_mode;
  logic [1:0] fld_mode;
  logic       embedded;
  logic       interl;

  assign rgb_on   = ctrl_q[ryvs_pkg::CTRL_RGB_ON];
  assign dual     = ctrl_q[ryvs_pkg::CTRL_DUAL_ADC];
  assign yuv_mode = ctrl_q[ryvs_pkg::CTRL_YUV_MODE +: 2];
  assign fld_mode = ctrl_q[ryvs_pkg::CTRL_FIELD_MODE +: 2];
  assign embedded = !rgb_on && (yuv_mode == ryvs_pkg::YUV_656);
  assign interl   = rgb_on ? ctrl_q[ryvs_pkg::CTRL_RGB_INTERL] : 1'b1;

  // Register writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q      <= ryvs_pkg::CTRL_RESET;
      v_off_q     <= ryvs_pkg::CNT_RESET;
      h_off_q     <= ryvs_pkg::CNT_RESET;
      v_len_q     <= ryvs_pkg::CNT_RESET;
      h_len_q     <= ryvs_pkg::CNT_RESET;
      clamp_on_q  <= ryvs_pkg::CNT_RESET;
      clamp_off_q <= ryvs_pkg::CNT_RESET;
      gainc_on_q  <= ryvs_pkg::CNT_RESET;
      gainc_off_q <= ryvs_pkg::CNT_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ryvs_pkg::ADDR_CTRL:      ctrl_q      <= reg_wdata;
        ryvs_pkg::ADDR_V_OFFSET:  v_off_q     <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_H_OFFSET:  h_off_q     <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_V_LENGTH:  v_len_q     <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_H_LENGTH:  h_len_q     <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_CLAMP_ON:  clamp_on_q  <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_CLAMP_OFF: clamp_off_q <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_GAINC_ON:  gainc_on_q  <= reg_wdata[CW-1:0];
        ryvs_pkg::ADDR_GAINC_OFF: gainc_off_q <= reg_wdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // Register reads, data in the following cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ryvs_pkg::ADDR_CTRL:      rdata_q <= ctrl_q;
        ryvs_pkg::ADDR_V_OFFSET:  rdata_q <= {4'h0, v_off_q};
        ryvs_pkg::ADDR_H_OFFSET:  rdata_q <= {4'h0, h_off_q};
        ryvs_pkg::ADDR_V_LENGTH:  rdata_q <= {4'h0, v_len_q};
        ryvs_pkg::ADDR_H_LENGTH:  rdata_q <= {4'h0, h_len_q};
        ryvs_pkg::ADDR_CLAMP_ON:  rdata_q <= {4'h0, clamp_on_q};
        ryvs_pkg::ADDR_CLAMP_OFF: rdata_q <= {4'h0, clamp_off_q};
        ryvs_pkg::ADDR_GAINC_ON:  rdata_q <= {4'h0, gainc_on_q};
        ryvs_pkg::ADDR_GAINC_OFF: rdata_q <= {4'h0, gainc_off_q};
        ryvs_pkg::ADDR_STATUS:    rdata_q <= {2'b00, capture_q, field_q, vcnt_q};
        default:                  rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;

  // Two-stage synchroniser for every pin, then one history stage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Masks sync edges until the history holds real pin levels, no false edge after reset
  logic [1:0] warm_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      warm_q <= 2'h0;
    end else if (warm_q != 2'h3) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  // Sync levels at programmed polarity and their edges
  logic vs_act;
  logic vs_act_p;
  logic hs_act;
  logic hs_act_p;
  logic vs_trail;
  logic hs_lead;
  logic hs_trail;
  logic horizontal_reference_in_rise;
  assign vs_act    = sync2_q.vsync == ctrl_q[ryvs_pkg::CTRL_VERTICAL_SYNC_POLARITY];
  assign vs_act_p  = prev_q.vsync == ctrl_q[ryvs_pkg::CTRL_VERTICAL_SYNC_POLARITY];
  assign hs_act    = sync2_q.hsync == ctrl_q[ryvs_pkg::CTRL_HORIZONTAL_SYNC_POLARITY];
  assign hs_act_p  = prev_q.hsync == ctrl_q[ryvs_pkg::CTRL_HORIZONTAL_SYNC_POLARITY];
  assign vs_trail  = (&warm_q) && !embedded && !vs_act && vs_act_p;
  assign hs_lead   = (&warm_q) && !embedded && hs_act && !hs_act_p;
  assign hs_trail  = (&warm_q) && !embedded && !hs_act && hs_act_p;
  assign horizontal_reference_in_rise = sync2_q.horizontal_reference_in && !prev_q.horizontal_reference_in;

  // Sample clock edges
  logic sclk_rise;
  logic sclk_fall;
  logic aclk_rise;
  logic qual_ok;
  logic sample_tick;
  logic hd_tick;
  assign sclk_rise = sync2_q.sclk && !prev_q.sclk;
  assign sclk_fall = !sync2_q.sclk && prev_q.sclk;
  assign aclk_rise = sync2_q.aclk && !prev_q.aclk;
  assign qual_ok   = sync2_q.qual == ctrl_q[ryvs_pkg::CTRL_QUAL_POL];

  always_comb begin
    if (rgb_on) begin
      sample_tick = sclk_rise || (dual && sclk_fall);
    end else if (ctrl_q[ryvs_pkg::CTRL_CLK_MUX]) begin
      sample_tick = aclk_rise && qual_ok;
    end else begin
      sample_tick = sclk_rise && qual_ok;
    end
  end

  // Half dot clock tick: every sample clock in dual mode, every second one otherwise
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      half_ph_q <= 1'b0;
    end else if (sclk_rise) begin
      half_ph_q <= !half_ph_q;
    end
  end

  assign hd_tick = sclk_rise && (dual || half_ph_q);

  // Embedded timing code parser
  logic [7:0] code_byte;
  logic       code_tick;
  logic       sav_tick;
  logic       fld_start_656;
  assign code_byte = sync2_q.port_a[7:0];
  assign code_tick = embedded && sample_tick && (cs_q == ryvs_pkg::CS_Z2);
  assign sav_tick  = code_tick && !code_byte[ryvs_pkg::CODE_H];
  assign fld_start_656 = sav_tick && !code_byte[ryvs_pkg::CODE_V] && code_v_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_q <= ryvs_pkg::CS_IDLE;
    end else if (embedded && sample_tick) begin
      case (cs_q)
        ryvs_pkg::CS_IDLE: begin
          cs_q <= (code_byte == ryvs_pkg::CODE_FF) ? ryvs_pkg::CS_FF : ryvs_pkg::CS_IDLE;
        end
        ryvs_pkg::CS_FF: begin
          cs_q <= (code_byte == ryvs_pkg::CODE_00) ? ryvs_pkg::CS_Z1 : ryvs_pkg::CS_IDLE;
        end
        ryvs_pkg::CS_Z1: begin
          cs_q <= (code_byte == ryvs_pkg::CODE_00) ? ryvs_pkg::CS_Z2 : ryvs_pkg::CS_IDLE;
        end
        default: cs_q <= ryvs_pkg::CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      code_v_q   <= 1'b1;
      code_act_q <= 1'b0;
    end else if (!embedded) begin
      code_act_q <= 1'b0;
    end else if (code_tick) begin
      code_v_q   <= code_byte[ryvs_pkg::CODE_V];
      code_act_q <= !code_byte[ryvs_pkg::CODE_H] && !code_byte[ryvs_pkg::CODE_V];
    end
  end

  // Line and frame events per source
  logic h_rst;
  logic v_inc;
  logic fld_start;
  logic new_fid;
  logic frame_begin;
  logic pix_tick;

  always_comb begin
    if (embedded) begin
      h_rst     = sav_tick;
      v_inc     = sav_tick;
      fld_start = fld_start_656;
      new_fid   = code_byte[ryvs_pkg::CODE_F];
      pix_tick  = sample_tick && code_act_q && (cs_q == ryvs_pkg::CS_IDLE)
                  && (code_byte != ryvs_pkg::CODE_FF);
    end else if (rgb_on) begin
      h_rst     = hs_trail;
      v_inc     = hs_trail;
      fld_start = vs_trail;
      new_fid   = interl && !field_q;
      pix_tick  = sample_tick;
    end else begin
      h_rst     = horizontal_reference_in_rise;
      v_inc     = hs_trail;
      fld_start = vs_trail;
      new_fid   = !field_q;
      pix_tick  = sample_tick && sync2_q.horizontal_reference_in;
    end
  end

  assign frame_begin = fld_start && !(interl && new_fid);

  // First sync edge after frame start opens line zero
  logic v_first_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      v_first_q <= 1'b0;
    end else if (frame_begin) begin
      v_first_q <= !embedded;
    end else if (v_inc) begin
      v_first_q <= 1'b0;
    end
  end

  // Horizontal and vertical position counters
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hcnt_q <= ryvs_pkg::CNT_RESET;
    end else if (h_rst) begin
      hcnt_q <= ryvs_pkg::CNT_RESET;
    end else if (pix_tick) begin
      hcnt_q <= sat_inc(hcnt_q);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vcnt_q <= ryvs_pkg::CNT_RESET;
    end else if (frame_begin) begin
      vcnt_q <= ryvs_pkg::CNT_RESET;
    end else if (v_inc && !v_first_q) begin
      vcnt_q <= sat_inc(vcnt_q);
    end
  end

  // Field identity and capture decision
  logic cap_d;
  always_comb begin
    case (fld_mode)
      ryvs_pkg::FLD_ALL: cap_d = 1'b1;
      ryvs_pkg::FLD_ALT: cap_d = new_fid != last_fid_q;
      ryvs_pkg::FLD_ODD: cap_d = new_fid;
      default:           cap_d = !new_fid;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      field_q    <= 1'b0;
      capture_q  <= 1'b1;
      last_fid_q <= 1'b1;
    end else if (fld_start) begin
      field_q   <= new_fid;
      capture_q <= rgb_on || cap_d;
      if (rgb_on || cap_d) begin
        last_fid_q <= new_fid;
      end
    end
  end

  // Port alternation for dual ADC mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sel_b_q <= 1'b0;
    end else if (hs_lead) begin
      sel_b_q <= ctrl_q[ryvs_pkg::CTRL_SAMPLE_SEQ];
    end else if (sample_tick && dual) begin
      sel_b_q <= !sel_b_q;
    end
  end

  // Pixel output with markers
  logic take;
  assign take = pix_tick && capture_q
                && in_window(hcnt_q, h_off_q, h_len_q)
                && in_window(vcnt_q, v_off_q, v_len_q);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_frame_q <= 1'b0;
      first_line_q  <= 1'b0;
    end else begin
      if (frame_begin) begin
        first_frame_q <= 1'b1;
      end else if (take) begin
        first_frame_q <= 1'b0;
      end
      if (h_rst) begin
        first_line_q <= 1'b1;
      end else if (take) begin
        first_line_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pix_q <= '0;
    end else begin
      pix_q.valid       <= take;
      pix_q.frame_start <= take && first_frame_q;
      pix_q.line_start  <= take && first_line_q;
      if (take) begin
        pix_q.data <= (rgb_on && dual && sel_b_q) ? sync2_q.port_b : sync2_q.port_a;
      end
    end
  end

  assign pixel_out = pix_q;

  // Clamp pulse timed from the trailing hsync edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hu_q <= ryvs_pkg::CNT_RESET;
    end else if (hs_trail) begin
      hu_q <= ryvs_pkg::CNT_RESET;
    end else if (hd_tick) begin
      hu_q <= sat_inc(hu_q);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clamp_q <= 1'b0;
    end else begin
      clamp_q <= ((hu_q >= clamp_on_q) && (hu_q < clamp_off_q))
                 == ctrl_q[ryvs_pkg::CTRL_CLAMP_POL];
    end
  end

  assign clamp_out = clamp_q;

  // Gain correction: hsync copy with separately delayed edges
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      g_lead_q      <= ryvs_pkg::CNT_RESET;
      g_trail_q     <= ryvs_pkg::CNT_RESET;
      g_lead_arm_q  <= 1'b0;
      g_trail_arm_q <= 1'b0;
      g_act_q       <= 1'b0;
    end else begin
      if (hs_lead) begin
        g_lead_q     <= ryvs_pkg::CNT_RESET;
        g_lead_arm_q <= 1'b1;
      end else if (g_lead_arm_q && (g_lead_q >= gainc_on_q)) begin
        g_lead_arm_q <= 1'b0;
        g_act_q      <= 1'b1;
      end else if (hd_tick) begin
        g_lead_q <= sat_inc(g_lead_q);
      end
      if (hs_trail) begin
        g_trail_q     <= ryvs_pkg::CNT_RESET;
        g_trail_arm_q <= 1'b1;
      end else if (g_trail_arm_q && (g_trail_q >= gainc_off_q)) begin
        g_trail_arm_q <= 1'b0;
        g_act_q       <= 1'b0;
      end else if (hd_tick) begin
        g_trail_q <= sat_inc(g_trail_q);
      end
    end
  end

  assign gain_correction_out = g_act_q == ctrl_q[ryvs_pkg::CTRL_GAINC_POL];

endmodule : ryvs_sampler

// ==== logic/ryvs_pkg.sv ====
// Package with constants and types of the RGB/YUV video input sampler
package ryvs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 12;
  localparam int PIX_W  = 24;

  // Register word addresses
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_V_OFFSET  = 4'h1;
  localparam logic [3:0] ADDR_H_OFFSET  = 4'h2;
  localparam logic [3:0] ADDR_V_LENGTH  = 4'h3;
  localparam logic [3:0] ADDR_H_LENGTH  = 4'h4;
  localparam logic [3:0] ADDR_CLAMP_ON  = 4'h5;
  localparam logic [3:0] ADDR_CLAMP_OFF = 4'h6;
  localparam logic [3:0] ADDR_GAINC_ON  = 4'h7;
  localparam logic [3:0] ADDR_GAINC_OFF = 4'h8;
  localparam logic [3:0] ADDR_STATUS    = 4'h9;

  // Control register fields
  localparam int CTRL_RGB_ON     = 0;
  localparam int CTRL_RGB_INTERL = 1;
  localparam int CTRL_DUAL_ADC   = 2;
  localparam int CTRL_SAMPLE_SEQ = 3;
  localparam int CTRL_VERTICAL_SYNC_POLARITY     = 4;
  localparam int CTRL_HORIZONTAL_SYNC_POLARITY     = 5;
  localparam int CTRL_CLAMP_POL  = 6;
  localparam int CTRL_GAINC_POL  = 7;
  localparam int CTRL_CLK_MUX    = 8;
  localparam int CTRL_QUAL_POL   = 9;
  localparam int CTRL_YUV_MODE   = 10;
  localparam int CTRL_FIELD_MODE = 12;

  // Status register fields
  localparam int STAT_FIELD   = 12;
  localparam int STAT_CAPTURE = 13;

  localparam logic [15:0]      CTRL_RESET = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_RESET  = 12'h000;

  // Input formats and field capture policies
  localparam logic [1:0] YUV_656 = 2'h0;
  localparam logic [1:0] FLD_ALL = 2'h0;
  localparam logic [1:0] FLD_ALT = 2'h1;
  localparam logic [1:0] FLD_ODD = 2'h2;

  // Embedded timing code bytes and flag positions
  localparam logic [7:0] CODE_FF = 8'hFF;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam int CODE_F = 6;
  localparam int CODE_V = 5;
  localparam int CODE_H = 4;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_FF   = 2'b01,
    CS_Z1   = 2'b10,
    CS_Z2   = 2'b11
  } ryvs_code_state_type;

  typedef struct packed {
    logic             vsync;
    logic             hsync;
    logic             horizontal_reference_in;
    logic             qual;
    logic             sclk;
    logic             aclk;
    logic [PIX_W-1:0] port_a;
    logic [PIX_W-1:0] port_b;
  } ryvs_pins_type;

  typedef struct packed {
    logic             valid;
    logic             frame_start;
    logic             line_start;
    logic [PIX_W-1:0] data;
  } ryvs_pixel_type;
endpackage : ryvs_pkg

// ==== testbench/ryvs_sampler_sva.sv ====
// Port checker for the video input sampler
`timescale 1ns/1ns
module ryvs_sampler_sva (
  input wire logic                     sys_clk,
  input wire logic                     nrst,
  input wire logic [3:0]               reg_addr,
  input wire logic [15:0]              reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [15:0]              reg_rdata,
  input wire ryvs_pkg::ryvs_pins_type  pins_in,
  input wire ryvs_pkg::ryvs_pixel_type pixel_out,
  input wire logic                     clamp_out,
  input wire logic                     gain_correction_out
);
  logic [15:0] ctrl_q;
  logic [3:0]  idle_q;
  logic        clk_q;
  logic        sel_clk;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  assign sel_clk = (ctrl_q[0] | ~ctrl_q[8]) ? pins_in.sclk : pins_in.aclk;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= ryvs_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == ryvs_pkg::ADDR_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  // Cycles since the selected sample clock last moved
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= 1'b0;
      idle_q <= 4'hF;
    end else begin
      clk_q <= sel_clk;
      idle_q <= (sel_clk != clk_q) ? 4'h0 : (idle_q == 4'hF ? idle_q : idle_q + 4'h1);
    end
  end

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ryvs_pkg::ADDR_STATUS |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_upper_zero: assert property (reg_rd && reg_addr != ryvs_pkg::ADDR_CTRL |=>
    reg_rdata[15:14] == 2'h0) else $error("unused read bits set");
  a_frame_marks: assert property (
    pixel_out.frame_start |-> pixel_out.valid && pixel_out.line_start)
    else $error("frame start without valid line start");
  a_valid_pulse: assert property (pixel_out.valid |=> !pixel_out.valid)
    else $error("valid longer than one cycle");
  a_edge_cause: assert property (pixel_out.valid |-> idle_q <= 4'h6)
    else $error("pixel without recent edge of selected clock");
  a_data_held: assert property (!pixel_out.valid |-> $stable(pixel_out.data))
    else $error("pixel data moved without valid");
  a_single_port: assert property (
    pixel_out.valid && ctrl_q[0] && !ctrl_q[2] |-> pixel_out.data == pins_in.port_a)
    else $error("single converter pixel not from port A");
  a_qual_gate: assert property (
    pixel_out.valid && !ctrl_q[0] |-> pins_in.qual == ctrl_q[9])
    else $error("video pixel taken with qualifier off");

  c_frame: cover property (pixel_out.frame_start);
  c_clamp: cover property ($changed(clamp_out));
  c_video: cover property (pixel_out.valid && !ctrl_q[0]);
endmodule : ryvs_sampler_sva

bind ryvs_sampler ryvs_sampler_sva u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
  .pixel_out(pixel_out), .clamp_out(clamp_out), .gain_correction_out(gain_correction_out)
);

// ==== testbench/ryvs_video_source.sv ====
// Behavioural converter or decoder driving the sampler pins
`timescale 1ns/1ns
module ryvs_video_source (
  output ryvs_pkg::ryvs_pins_type pins
);
  initial begin
    pins = '0;
    pins.vsync = 1'b1;
    pins.hsync = 1'b1;
  end

  task automatic edge_to(input logic al, input logic v);
    if (al) begin
      pins.aclk = v;
    end else begin
      pins.sclk = v;
    end
  endtask : edge_to

  task automatic send_frame(input int nl, input int np, input logic hp, input logic vp,
                            input logic ql, input logic al, input logic dl);
    #13;
    pins.qual = ql;
    pins.hsync = ~hp;
    pins.vsync = ~vp;
    #800;
    pins.vsync = vp;
    #800;
    pins.vsync = ~vp;
    #800;
    for (int l = 0; l < nl; l++) begin
      pins.hsync = hp;
      #400;
      pins.hsync = ~hp;
      pins.horizontal_reference_in = 1'b1;
      #400;
      for (int c = 0; c < (dl ? np / 2 : np); c++) begin
        pins.port_a = {8'h0A, l[7:0], c[7:0]};
        pins.port_b = {8'h0B, l[7:0], c[7:0]};
        #100;
        edge_to(al, 1'b1);
        #200;
        edge_to(al, 1'b0);
        #100;
      end
      pins.horizontal_reference_in = 1'b0;
      pins.port_a = ~pins.port_a;
      pins.port_b = ~pins.port_b;
      #800;
    end
  endtask : send_frame
endmodule : ryvs_video_source

// ==== testbench/ryvs_sampler_tb.sv ====
// Self-checking bench for the video input sampler
`timescale 1ns/1ns
module ryvs_sampler_tb;
  logic                     sys_clk;
  logic                     nrst;
  logic [3:0]               reg_addr;
  logic [15:0]              reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [15:0]              reg_rdata;
  ryvs_pkg::ryvs_pins_type  pins;
  ryvs_pkg::ryvs_pixel_type pix;
  logic                     clamp_out;
  logic                     gain_out;
  logic                     act;
  logic                     clamp_seen;
  logic                     gain_seen;
  logic                     ign_fs;
  logic [25:0]              exp_q[$];
  logic [8:0]               e;
  int                       err_count;
  int                       total_checks;
  // Video cases: field policy, expect, format, qual polarity, level, clock select, clock used
  localparam logic [8:0] YT [7] = '{9'h1DC, 9'h160, 9'h038, 9'h0EF, 9'h120, 9'h02E, 9'h00C};

  ryvs_sampler u_dut (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pins_in(pins),
    .pixel_out(pix),
    .clamp_out(clamp_out),
    .gain_correction_out(gain_out)
  );
  ryvs_video_source u_src (.pins(pins));

  always #25 sys_clk = ~sys_clk;

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata === x, "read data");
  endtask : rd

  task automatic win(input logic [15:0] vo, ho, vl, hl);
    wr(ryvs_pkg::ADDR_V_OFFSET, vo);
    wr(ryvs_pkg::ADDR_H_OFFSET, ho);
    wr(ryvs_pkg::ADDR_V_LENGTH, vl);
    wr(ryvs_pkg::ADDR_H_LENGTH, hl);
  endtask : win

  task automatic build(input int nl, np, vo, vl, ho, hl, input logic dl, sq);
    logic fs;
    logic ls;
    int   k;
    fs = 1'b1;
    for (int l = vo; l < nl && l < vo + vl; l++) begin
      ls = 1'b1;
      for (int p = ho; p < np && p < ho + hl; p++) begin
        k = dl ? p / 2 : p;
        exp_q.push_back({fs, ls, (dl && (p % 2) != int'(sq)) ? 8'h0B : 8'h0A, l[7:0], k[7:0]});
        fs = 1'b0;
        ls = 1'b0;
      end
    end
  endtask : build

  task automatic run(input string name, input int nl, np, input logic hp, ql, al, dl);
    u_src.send_frame(nl, np, hp, hp, ql, al, dl);
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge sys_clk);
    chk(exp_q.size() == 0, "pixels missing");
    exp_q.delete();
    $display("Test %s done", name);
  endtask : run

  always @(posedge sys_clk) begin
    if (clamp_out === act) clamp_seen = 1'b1;
    if (gain_out === act) gain_seen = 1'b1;
    if (pix.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1'b0, "unexpected pixel");
      end else begin
        chk({pix.frame_start | ign_fs, pix.line_start, pix.data} === (exp_q[0] | {ign_fs, 25'h0}),
            "pixel");
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    #1000000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    act = 1'b0;
    ign_fs = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(ryvs_pkg::ADDR_CTRL, ryvs_pkg::CTRL_RESET);
    for (int a = 1; a < 9; a++) rd(a[3:0], 16'h0000);
    wr(4'hA, 16'hFFFF);
    rd(4'hA, 16'h0000);
    wr(ryvs_pkg::ADDR_H_LENGTH, 16'hFFFF);
    rd(ryvs_pkg::ADDR_H_LENGTH, 16'h0FFF);
    chk(clamp_out === 1'b1 && gain_out === 1'b1, "idle levels");
    $display("Test registers done");
    win(16'h0000, 16'h0002, 16'h0002, 16'h0004);
    wr(ryvs_pkg::ADDR_CLAMP_ON, 16'h0001);
    wr(ryvs_pkg::ADDR_CLAMP_OFF, 16'h0003);
    clamp_seen = 1'b0;
    gain_seen = 1'b0;
    build(3, 8, 0, 2, 2, 4, 1'b0, 1'b0);
    run("rgb_single", 3, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(clamp_seen === 1'b1 && gain_seen === 1'b1, "pulses");
    act = 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(ryvs_pkg::ADDR_CTRL, 16'h00F5 | {12'h000, s[0], 3'h0});
      repeat (3) @(posedge sys_clk);
      chk(clamp_out === 1'b0, "clamp idle level");
      clamp_seen = 1'b0;
      gain_seen = 1'b0;
      win(16'h0001, 16'h0001, 16'h0001, 16'h0006);
      build(3, 8, 1, 1, 1, 6, 1'b1, s[0]);
      run("rgb_dual", 3, 8, 1'b1, 1'b0, 1'b0, 1'b1);
      chk(clamp_seen === 1'b1 && gain_seen === 1'b1, "pulses");
    end
    ign_fs = 1'b1;
    win(16'h0000, 16'h0000, 16'h0FFF, 16'h0004);
    for (int i = 0; i < 7; i++) begin
      e = YT[i];
      wr(ryvs_pkg::ADDR_CTRL, {2'h0, e[8:7], e[5:4], e[3], e[1], 8'h00});
      if (e[6]) build(2, 4, 0, 4095, 0, 4, 1'b0, 1'b0);
      run("yuv", 2, 4, 1'b0, e[2], e[0], 1'b0);
      if (i == 4) rd(ryvs_pkg::ADDR_STATUS, 16'h0001);
    end
    finish_test();
  end
endmodule : ryvs_sampler_tb
